// File: verilog/fidw_consts.svh
// Function
// - Deep sleep ignores all but wake command.
// - Plain wake: opcode, raise select, resume later.
// - Host keeps select high during wake delay.
// - Plain wake delay at most 3 microseconds.
// - Wake plus three dummy bytes returns identifier; from deep sleep the code leaves the line released and the host reads FFh.
// - Identifier eight bits, falling edge, MSB first.
// - Identifier byte repeats while host keeps clocking.
// - Raising select ends read, output released.
// - Identifier wake needs identifier wake delay.
// - Identifier wake delay at most 1.8 microseconds.
// - Wake ignored while write in progress.
// - Opcode 90h, address zero: manufacturer then device.
// - Address one: device byte before manufacturer byte.
// - Opcode 9Fh: manufacturer, memory type, capacity.
// Purpose: Constants shared by both ends of the identifier command link.
// Assumes: 50 MHz system clock.
// Notes:   Identity values are arbitrary.
`ifndef FIDW_CONSTS_SVH
`define FIDW_CONSTS_SVH
`define FIDW_OP_WAKE       8'hAB
`define FIDW_OP_MFR_DEV    8'h90
`define FIDW_OP_STD_ID     8'h9F
`define FIDW_OP_SLEEP      8'hB9
`define FIDW_MFR_ID        8'h5A
`define FIDW_DEV_ID        8'h3C
`define FIDW_MEM_TYPE      8'h40
`define FIDW_CAPACITY      8'h15
`define FIDW_CLK_MHZ       50
`define FIDW_PLAIN_WAKE_NS 3000
`define FIDW_ID_WAKE_NS    1800
`define FIDW_PLAIN_WAKE_CYC ((`FIDW_PLAIN_WAKE_NS * `FIDW_CLK_MHZ) / 1000)
`define FIDW_ID_WAKE_CYC    ((`FIDW_ID_WAKE_NS * `FIDW_CLK_MHZ) / 1000)
`define FIDW_SCK_HALF      8'h04
`define FIDW_CS_GAP        8'h08
`define FIDW_SYNC_LAT      3
`define FIDW_RELEASED_BYTE 8'hFF
`endif

// File: verilog/fidw_pkg.sv
// Purpose: Types shared by both ends.
// Assumes: Nothing.
// Notes:   None.
package fidw_pkg;
    typedef enum logic [1:0] {
        FIDW_CMD_WAKE   = 2'h0,
        FIDW_CMD_MFR    = 2'h1,
        FIDW_CMD_STD_ID = 2'h2,
        FIDW_CMD_SLEEP  = 2'h3
    } fidw_cmd_t;
endpackage

// File: verilog/fidw_link_if.sv
// Purpose: Serial link between host controller and identifier device.
// Assumes: Host drives select and clock; device drives data out.
// Notes:   Output enable of the device data pin is low while driving.
`timescale 1ns/100ps
`default_nettype none
interface fidw_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    modport host (output cs_n, output sck, output mosi, input miso_o, input miso_oe_n);
    modport dev  (input cs_n, input sck, input mosi, output miso_o, output miso_oe_n);
endinterface
`default_nettype wire

// File: verilog/fidw_sync.sv
// Purpose: Two-flop synchroniser with edge detection for one link pin.
// Assumes: Input is asynchronous to mclk.
// Notes:   Edges come from the second flop and its copy.
`timescale 1ns/100ps
`default_nettype none
module fidw_sync (
    input  wire logic mclk,
    input  wire logic arst_n,
    input  wire logic din,
    input  wire logic rst_val,
    output var  logic dout,
    output var  logic rise,
    output var  logic fall
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign dout = s2_q;
    assign rise = s2_q & ~s3_q & ~rst_val;
    assign fall = ~s2_q & s3_q & ~rst_val;
endmodule
`default_nettype wire

// File: verilog/fidw_device.sv
// Purpose: Flash identifier and wake command logic, device end.
// Assumes: Mode-0 framing; write cycles are signalled by a plain input.
// Notes:   Sleep entry is accepted so that wake has something to leave.
`timescale 1ns/100ps
`default_nettype none
`include "fidw_consts.svh"
module fidw_device (
    input  wire logic mclk,
    input  wire logic arst_n,
    fidw_link_if.dev  link,
    input  wire logic write_in_progress_flag,
    output var  logic deep_sleep_mode,
    output var  logic wake_busy
);
    import fidw_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic cs_n_s;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic mosi_s;
    fidw_sync u_cs (.mclk(mclk), .arst_n(arst_n), .din(link.cs_n), .rst_val(1'b0),
                    .dout(cs_n_s), .rise(cs_rise), .fall(cs_fall));
    fidw_sync u_sck (.mclk(mclk), .arst_n(arst_n), .din(link.sck), .rst_val(cs_n_s),
                     .dout(), .rise(sck_rise), .fall(sck_fall));
    fidw_sync u_mosi (.mclk(mclk), .arst_n(arst_n), .din(link.mosi), .rst_val(1'b0),
                      .dout(mosi_s), .rise(), .fall());

    // ------------------------------------------------------------
    // Frame decoding
    // ------------------------------------------------------------
    logic [5:0]  bit_cnt_q;
    logic [7:0]  op_q;
    logic [23:0] addr_q;
    logic [7:0]  shift_in;
    assign shift_in = {op_q[6:0], mosi_s};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_q <= 6'h00;
            op_q      <= 8'h00;
            addr_q    <= 24'h000000;
        end else if (cs_fall) begin
            bit_cnt_q <= 6'h00;
        end else if (sck_rise) begin
            if (bit_cnt_q != 6'h3F) begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            if (bit_cnt_q < 6'h08) begin
                op_q <= shift_in;
            end else if (bit_cnt_q < 6'h20) begin
                addr_q <= {addr_q[22:0], mosi_s};
            end
        end
    end

    // ------------------------------------------------------------
    // Sleep and wake
    // ------------------------------------------------------------
    logic [7:0] wake_cnt_q;
    logic       op_done;
    assign op_done = cs_rise && (bit_cnt_q >= 6'h08);
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            deep_sleep_mode <= 1'b0;
            wake_busy       <= 1'b0;
            wake_cnt_q      <= 8'h00;
        end else if (op_done && op_q == `FIDW_OP_WAKE && !write_in_progress_flag
                     && !wake_busy) begin
            deep_sleep_mode <= 1'b0;
            if (deep_sleep_mode) begin
                wake_busy  <= 1'b1;
                // Synchroniser latency is taken off so the delay counts from the pin.
                wake_cnt_q <= (bit_cnt_q == 6'h08)
                              ? 8'(`FIDW_PLAIN_WAKE_CYC - `FIDW_SYNC_LAT)
                              : 8'(`FIDW_ID_WAKE_CYC - `FIDW_SYNC_LAT);
            end
        end else if (op_done && op_q == `FIDW_OP_SLEEP && bit_cnt_q == 6'h08
                     && !deep_sleep_mode && !wake_busy && !write_in_progress_flag) begin
            deep_sleep_mode <= 1'b1;
        end else if (wake_busy) begin
            if (wake_cnt_q <= 8'h01) begin
                wake_busy <= 1'b0;
            end
            wake_cnt_q <= wake_cnt_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Identifier output
    // ------------------------------------------------------------
    logic       active;
    logic [7:0] out_byte;
    logic [1:0] byte_sel;
    always_comb begin
        active   = 1'b0;
        out_byte = 8'h00;
        byte_sel = bit_cnt_q[4:3];
        if (!deep_sleep_mode && !wake_busy && !write_in_progress_flag) begin
            if (op_q == `FIDW_OP_WAKE && bit_cnt_q >= 6'h20) begin
                active   = 1'b1;
                out_byte = `FIDW_DEV_ID;
            end else if (op_q == `FIDW_OP_MFR_DEV && bit_cnt_q >= 6'h20) begin
                active = 1'b1;
                if (addr_q[0] ^ byte_sel[0]) begin
                    out_byte = `FIDW_DEV_ID;
                end else begin
                    out_byte = `FIDW_MFR_ID;
                end
            end else if (op_q == `FIDW_OP_STD_ID && bit_cnt_q >= 6'h08) begin
                active = 1'b1;
                // Past the third byte the capacity byte repeats.
                unique case (bit_cnt_q[5] ? 2'h3 : byte_sel)
                    2'h1:    out_byte = `FIDW_MFR_ID;
                    2'h2:    out_byte = `FIDW_MEM_TYPE;
                    default: out_byte = `FIDW_CAPACITY;
                endcase
            end
        end
    end

    logic [2:0] obit_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            link.miso_o    <= 1'b0;
            link.miso_oe_n <= 1'b1;
            obit_q         <= 3'h7;
        end else if (cs_rise) begin
            link.miso_oe_n <= 1'b1;
            obit_q         <= 3'h7;
        end else if (sck_fall && active && !cs_n_s) begin
            link.miso_oe_n <= 1'b0;
            link.miso_o    <= out_byte[obit_q];
            obit_q         <= obit_q - 3'h1;
        end
    end
endmodule
`default_nettype wire

// File: verilog/fidw_host.sv
// Purpose: Host controller end issuing wake and identifier commands.
// Assumes: Divider makes the serial clock from mclk.
// Notes:   Returns the last received byte.
`timescale 1ns/100ps
`default_nettype none
`include "fidw_consts.svh"
module fidw_host (
    input  wire logic      mclk,
    input  wire logic      arst_n,
    fidw_link_if.host      link,
    input  wire logic      start,
    input  wire fidw_pkg::fidw_cmd_t cmd,
    input  wire logic [23:0] addr,
    input  wire logic [2:0]  rd_bytes,
    input  wire logic      was_sleeping,
    output var  logic      busy,
    output var  logic      rx_valid,
    output var  logic [7:0] rx_byte
);
    import fidw_pkg::*;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {H_IDLE = 2'b00, H_SHIFT = 2'b01, H_GAP = 2'b11} fidw_hst_t;
    fidw_hst_t   st_q;
    logic [7:0]  div_q;
    logic [6:0]  nbits_q;
    logic [6:0]  cnt_q;
    logic [31:0] tx_q;
    logic [7:0]  rx_q;
    logic [7:0]  gap_q;
    logic        miso_s1_q;
    logic        miso_s2_q;
    logic [7:0]  op;
    logic [6:0]  hdr;
    logic [7:0]  rx_next;
    assign rx_next = {rx_q[6:0], miso_s2_q};
    always_comb begin
        op  = `FIDW_OP_WAKE;
        hdr = 7'd32;
        unique case (cmd)
            FIDW_CMD_WAKE:   begin op = `FIDW_OP_WAKE; hdr = (rd_bytes == 3'h0) ? 7'd8 : 7'd32; end
            FIDW_CMD_MFR:    begin op = `FIDW_OP_MFR_DEV; hdr = 7'd32; end
            FIDW_CMD_STD_ID: begin op = `FIDW_OP_STD_ID; hdr = 7'd8; end
            FIDW_CMD_SLEEP:  begin op = `FIDW_OP_SLEEP; hdr = 7'd8; end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            miso_s1_q <= 1'b1;
            miso_s2_q <= 1'b1;
        end else begin
            // A released data line reads high, as if pulled up.
            miso_s1_q <= link.miso_o | link.miso_oe_n;
            miso_s2_q <= miso_s1_q;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q      <= H_IDLE;
            div_q     <= 8'h00;
            nbits_q   <= 7'h00;
            cnt_q     <= 7'h00;
            tx_q      <= 32'h00000000;
            rx_q      <= 8'h00;
            gap_q     <= 8'h00;
            link.cs_n <= 1'b1;
            link.sck  <= 1'b0;
            link.mosi <= 1'b0;
            busy      <= 1'b0;
            rx_valid  <= 1'b0;
            rx_byte   <= 8'h00;
        end else begin
            rx_valid <= 1'b0;
            unique case (st_q)
                H_IDLE: begin
                    if (start) begin
                        st_q      <= H_SHIFT;
                        busy      <= 1'b1;
                        link.cs_n <= 1'b0;
                        tx_q      <= {op, addr};
                        link.mosi <= op[7];
                        nbits_q   <= 7'(hdr + {1'b0, rd_bytes, 3'h0});
                        cnt_q     <= 7'h00;
                        div_q     <= 8'h00;
                    end
                end
                H_SHIFT: begin
                    div_q <= div_q + 8'h01;
                    if (div_q == `FIDW_SCK_HALF) begin
                        div_q <= 8'h00;
                        if (cnt_q == nbits_q) begin
                            link.cs_n <= 1'b1;
                            st_q      <= H_GAP;
                            gap_q     <= (cmd == FIDW_CMD_WAKE && hdr == 7'd8)
                                         ? 8'(`FIDW_PLAIN_WAKE_CYC)
                                         : (was_sleeping && cmd == FIDW_CMD_WAKE)
                                         ? 8'(`FIDW_ID_WAKE_CYC)
                                         : `FIDW_CS_GAP;
                        end else if (!link.sck) begin
                            link.sck <= 1'b1;
                        end else begin
                            // Data is taken late in the high phase, once through both flops.
                            link.sck  <= 1'b0;
                            cnt_q     <= cnt_q + 7'h01;
                            tx_q      <= {tx_q[30:0], 1'b0};
                            link.mosi <= tx_q[30];
                            rx_q      <= rx_next;
                            if (cnt_q >= hdr && cnt_q[2:0] == 3'h7) begin
                                rx_valid <= 1'b1;
                                rx_byte  <= rx_next;
                            end
                        end
                    end
                end
                H_GAP: begin
                    gap_q <= gap_q - 8'h01;
                    if (gap_q <= 8'h01) begin
                        st_q <= H_IDLE;
                        busy <= 1'b0;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// File: test/fidw_link_props.sv
// Purpose: Checks on the serial link between the two ends.
// Assumes: Sees only the interface signals, clock and reset.
// Notes:   A small frame model tracks opcode, bit count and gap.
`timescale 1ns/100ps
`default_nettype none
`include "fidw_consts.svh"
module fidw_link_props (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n
);
    logic [5:0] bits_q;
    logic [7:0] op_q;
    logic [7:0] lop_q;
    logic [5:0] lbits_q;
    logic [8:0] gap_q;
    logic       sleep_q;
    logic       idw_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------
    // Frame model.
    // ----------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bits_q <= 6'h00;
            op_q   <= 8'h00;
        end else if (cs_n) begin
            bits_q <= 6'h00;
        end else if ($rose(sck) && bits_q != 6'h3F) begin
            bits_q <= bits_q + 6'h01;
            if (bits_q < 6'h08) op_q <= {op_q[6:0], mosi};
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lop_q   <= 8'h00;
            lbits_q <= 6'h00;
            sleep_q <= 1'b0;
            idw_q   <= 1'b0;
        end else if ($rose(cs_n)) begin
            lop_q   <= op_q;
            lbits_q <= bits_q;
            idw_q   <= sleep_q && op_q == `FIDW_OP_WAKE && bits_q > 6'h08;
            if (op_q == `FIDW_OP_SLEEP && bits_q == 6'h08) sleep_q <= 1'b1;
            else if (op_q == `FIDW_OP_WAKE) sleep_q <= 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) gap_q <= 9'h000;
        else if (!cs_n) gap_q <= 9'h000;
        else if (gap_q != 9'h1FF) gap_q <= gap_q + 9'h001;
    end
    property p_idle_sck; cs_n |-> !sck; endproperty
    a_idle_sck: assert property (p_idle_sck) else $error("clock not low outside frame");
    property p_mosi_hold; !cs_n && $rose(sck) |-> $stable(mosi); endproperty
    a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved at rising clock");
    property p_miso_fall;
        !miso_oe_n && $past(!miso_oe_n) && $changed(miso_o) |-> !sck;
    endproperty
    a_miso_fall: assert property (p_miso_fall) else $error("data changed in clock high");
    property p_release; $rose(cs_n) |-> ##[0:5] miso_oe_n; endproperty
    a_release: assert property (p_release) else $error("data not released");
    property p_quiet_idle; cs_n [*6] |-> miso_oe_n; endproperty
    a_quiet_idle: assert property (p_quiet_idle) else $error("driving while deselected");
    property p_read_start;
        $fell(miso_oe_n) |-> (op_q == `FIDW_OP_STD_ID) ? bits_q == 6'h08 : bits_q == 6'h20;
    endproperty
    a_read_start: assert property (p_read_start) else $error("read began at wrong bit");
    property p_sleep_quiet; sleep_q |-> miso_oe_n; endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("data given in sleep");
    property p_plain_gap;
        $fell(cs_n) && lop_q == `FIDW_OP_WAKE && lbits_q == 6'h08
            |-> gap_q >= `FIDW_PLAIN_WAKE_CYC - 1;
    endproperty
    a_plain_gap: assert property (p_plain_gap) else $error("plain wake gap short");
    property p_id_gap; $fell(cs_n) && idw_q |-> gap_q >= `FIDW_ID_WAKE_CYC - 1; endproperty
    a_id_gap: assert property (p_id_gap) else $error("identifier wake gap short");
    c_std: cover property ($fell(miso_oe_n) && op_q == `FIDW_OP_STD_ID);
    c_plain: cover property ($fell(cs_n) && lop_q == `FIDW_OP_WAKE && lbits_q == 6'h08);
    c_idw: cover property ($fell(cs_n) && idw_q);
endmodule
`default_nettype wire

// File: test/tb_flash_id_and_wake_commands.sv
// Purpose: Bench for host and device ends joined by one link.
// Assumes: The host makes the serial clock from mclk.
// Notes:   The driver queues expected bytes; a monitor pops them.
`timescale 1ns/100ps
`default_nettype none
`include "fidw_consts.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_flash_id_and_wake_commands;
    import fidw_pkg::*;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        start = 1'b0;
    fidw_cmd_t   cmd = FIDW_CMD_WAKE;
    logic [23:0] addr = 24'h000000;
    logic [2:0]  rd_bytes = 3'h0;
    logic        was_sleeping = 1'b0;
    logic        wr_flag = 1'b0;
    logic        busy;
    logic        rx_valid;
    logic [7:0]  rx_byte;
    logic        deep_sleep_mode;
    logic        wake_busy;
    logic [7:0]  exp_q[$];
    logic [7:0]  e_v;
    int          wake_cyc = 0;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    fidw_link_if link ();
    fidw_host i_fidw_host (.mclk(mclk), .arst_n(arst_n), .link(link), .start(start),
        .cmd(cmd), .addr(addr), .rd_bytes(rd_bytes), .was_sleeping(was_sleeping),
        .busy(busy), .rx_valid(rx_valid), .rx_byte(rx_byte));
    fidw_device i_fidw_device (.mclk(mclk), .arst_n(arst_n), .link(link),
        .write_in_progress_flag(wr_flag), .deep_sleep_mode(deep_sleep_mode),
        .wake_busy(wake_busy));
    fidw_link_props i_fidw_link_props (.mclk(mclk), .arst_n(arst_n), .cs_n(link.cs_n),
        .sck(link.sck), .mosi(link.mosi), .miso_o(link.miso_o), .miso_oe_n(link.miso_oe_n));
    always #10 mclk = ~mclk;
    // ----------------------------------------
    // Monitor, timeout and closing.
    // ----------------------------------------
    always @(negedge mclk) begin
        if (wake_busy === 1'b1) begin
            wake_cyc++;
        end
    end
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) begin
            e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
            `CHK("rx_byte", e_v, rx_byte)
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic run(input fidw_cmd_t c, input logic [23:0] a, input logic [2:0] n,
                       input logic s);
        int k;
        @(negedge mclk);
        cmd = c;
        addr = a;
        rd_bytes = n;
        was_sleeping = s;
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        k = 0;
        while (busy === 1'b1 && k < 3000) begin
            @(negedge mclk);
            k++;
        end
        if (busy !== 1'b0) begin
            bad_count++;
            report_and_stop();
        end
    endtask
    task automatic fin(input string nm);
        `CHK("bytes_left", 0, exp_q.size())
        $display("test %s done", nm);
    endtask
    initial begin
        logic [23:0] a;
        void'($urandom(32'h5B96B8F4));
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        arst_n = 1'b1;
        exp_q = '{`FIDW_MFR_ID, `FIDW_MEM_TYPE, `FIDW_CAPACITY,
                  `FIDW_CAPACITY, `FIDW_CAPACITY};
        run(FIDW_CMD_STD_ID, 24'h000000, 3'h5, 1'b0);
        fin("std_id");
        repeat (4) begin
            a = {23'h000000, 1'($urandom)};
            exp_q = a[0] ? '{`FIDW_DEV_ID, `FIDW_MFR_ID} : '{`FIDW_MFR_ID, `FIDW_DEV_ID};
            run(FIDW_CMD_MFR, a, 3'h2, 1'b0);
            fin("mfr_dev");
        end
        exp_q = '{`FIDW_DEV_ID, `FIDW_DEV_ID, `FIDW_DEV_ID};
        run(FIDW_CMD_WAKE, 24'h000000, 3'h3, 1'b0);
        fin("id_read");
        run(FIDW_CMD_SLEEP, 24'h000000, 3'h0, 1'b0);
        exp_q = '{`FIDW_RELEASED_BYTE, `FIDW_RELEASED_BYTE, `FIDW_RELEASED_BYTE};
        run(FIDW_CMD_STD_ID, 24'h000000, 3'h3, 1'b0);
        `CHK("sleep_kept", 1'b1, deep_sleep_mode)
        fin("sleep_ignore");
        wr_flag = 1'b1;
        wake_cyc = 0;
        run(FIDW_CMD_WAKE, 24'h000000, 3'h0, 1'b1);
        `CHK("wake_refused", 1'b1, deep_sleep_mode)
        `CHK("refused_idle", 0, wake_cyc)
        wr_flag = 1'b0;
        wake_cyc = 0;
        run(FIDW_CMD_WAKE, 24'h000000, 3'h0, 1'b1);
        `CHK("plain_awake", 1'b0, deep_sleep_mode)
        `CHK("plain_delay", 1'b0, wake_busy)
        `CHK("plain_span", 1'b1, wake_cyc > 0 && wake_cyc <= `FIDW_PLAIN_WAKE_CYC)
        fin("plain_wake");
        run(FIDW_CMD_SLEEP, 24'h000000, 3'h0, 1'b0);
        wake_cyc = 0;
        exp_q = '{`FIDW_RELEASED_BYTE};
        run(FIDW_CMD_WAKE, 24'h000000, 3'h1, 1'b1);
        `CHK("id_awake", 1'b0, deep_sleep_mode)
        `CHK("id_delay", 1'b0, wake_busy)
        `CHK("id_span", 1'b1, wake_cyc > 0 && wake_cyc <= `FIDW_ID_WAKE_CYC)
        fin("id_wake_sleep");
        exp_q = '{`FIDW_MFR_ID, `FIDW_DEV_ID};
        run(FIDW_CMD_MFR, 24'h000000, 3'h2, 1'b0);
        fin("id_wake");
        report_and_stop();
    end
endmodule
`default_nettype wire
